//--- rtl/cslp_in_sync.sv
`timescale 1ns/10ps
module cslp_in_sync
(
  input wire logic i_clk_sys,     // System clock
  input wire logic i_rst_b,       // Async reset, active low
  input wire logic [3:0] i_async, // lpc clk, sleep, deeper, pstate
  cslp_sync_if.src o_sync         // Synchronised levels and edge
);
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic lpc_prev_q;

  // ----------------------------------------------------------------
  // Two-flop synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
      lpc_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
      lpc_prev_q <= sync_q[0];
    end
  end

  assign o_sync.lpc_clk_rise = sync_q[0] & ~lpc_prev_q;
  assign o_sync.sleep_req = sync_q[1];
  assign o_sync.deeper_req = sync_q[2];
  assign o_sync.pstate_busy = sync_q[3];
endmodule

//--- rtl/cslp_pkg.sv
package cslp_pkg;
  // ----------------------------------------------------------------
  // Sequencing timing counts (cycles of i_clk_sys)
  // ----------------------------------------------------------------
  localparam int unsigned CSLP_CLK_NS = 4;
  localparam int unsigned CSLP_STPCLK_SETUP_NS = 40;
  localparam int unsigned CSLP_STPCLK_SETUP_CYC =
    (CSLP_STPCLK_SETUP_NS + CSLP_CLK_NS - 1) / CSLP_CLK_NS;
  localparam int unsigned CSLP_CLK_RUN_NS = 40;
  localparam int unsigned CSLP_CLK_RUN_CYC =
    (CSLP_CLK_RUN_NS + CSLP_CLK_NS - 1) / CSLP_CLK_NS;
  localparam int unsigned CSLP_CNT_W = 8;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSLP_RUN      = 3'b000,
    CSLP_STOP     = 3'b001,
    CSLP_DEEP     = 3'b010,
    CSLP_DEEPER   = 3'b011,
    CSLP_DEEP_EXIT = 3'b100,
    CSLP_CLK_WAIT = 3'b101
  } cslp_state_t;
endpackage

//--- rtl/cslp_seq.sv
`timescale 1ns/10ps
// Contract
// - Drive deep sleep low to make the processor gate its core clock.
// - Deep sleep defaults high and returns high to leave deep sleep.
// - Deep sleep and stop-clock request are separate outputs.
// - Deep sleep stays asserted longer than the stop-clock request.
// - Assert deeper sleep to move from deep to deeper sleep.
// - Deassert deeper sleep to return from deeper to deep sleep.
// - Keep power good high through every voltage/frequency change.
// - The host reference clock times the bus and core/memory clocks.
// - Assert stop-clock request on a low-pin-count clock edge.
module cslp_seq
  import cslp_pkg::*;
#(
  parameter int unsigned SETUP_CYC = CSLP_STPCLK_SETUP_CYC,
  parameter int unsigned RUN_CYC = CSLP_CLK_RUN_CYC
)
(
  input wire logic i_clk_sys,       // System clock from host PLL
  input wire logic i_rst_b,         // Async reset, active low
  input wire logic i_lpc_clk,       // LPC bus clock, sampled
  input wire logic i_sleep_req,     // Power event: enter sleep
  input wire logic i_deeper_req,    // Power event: go deeper
  input wire logic i_pstate_busy,   // Voltage/freq change running
  input wire logic i_power_ok,      // Platform power is good
  output logic o_stop_clock_request_n, // To processor, active low
  output logic o_deep_sleep_n,      // To processor, active low
  output logic o_deeper_sleep_n,    // To processor, active low
  output logic o_cpu_power_good     // To processor
);
  cslp_sync_if sync_if ();
  cslp_state_t state_q;
  logic [CSLP_CNT_W-1:0] cnt_q;
  logic cnt_done;
  logic pwr_meta_q;
  logic pwr_sync_q;

  cslp_in_sync u_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_b (i_rst_b),
    .i_async ({i_pstate_busy, i_deeper_req, i_sleep_req, i_lpc_clk}),
    .o_sync (sync_if.src)
  );

  assign cnt_done = (cnt_q == '0);

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_q <= CSLP_RUN;
      cnt_q <= '0;
    end
    else
    begin
      if (!cnt_done)
      begin
        cnt_q <= cnt_q - 1'b1;
      end
      unique case (state_q)
        CSLP_RUN:
        begin
          if (sync_if.sleep_req && sync_if.lpc_clk_rise)
          begin
            state_q <= CSLP_STOP;
            cnt_q <= CSLP_CNT_W'(SETUP_CYC);
          end
        end
        CSLP_STOP:
        begin
          // abort waits for LPC edge
          // Deep sleep never asserted on abort, so skip the clock wait
          if (!sync_if.sleep_req)
          begin
            if (sync_if.lpc_clk_rise)
            begin
              state_q <= CSLP_RUN;
            end
          end
          else if (cnt_done)
          begin
            state_q <= CSLP_DEEP;
          end
        end
        CSLP_DEEP:
        begin
          if (!sync_if.sleep_req)
          begin
            state_q <= CSLP_DEEP_EXIT;
          end
          else if (sync_if.deeper_req)
          begin
            state_q <= CSLP_DEEPER;
          end
        end
        CSLP_DEEPER:
        begin
          if (!sync_if.deeper_req || !sync_if.sleep_req)
          begin
            state_q <= CSLP_DEEP;
          end
        end
        CSLP_DEEP_EXIT:
        begin
          // release stop clock first, on LPC edge
          if (sync_if.lpc_clk_rise)
          begin
            state_q <= CSLP_CLK_WAIT;
            cnt_q <= CSLP_CNT_W'(RUN_CYC);
          end
        end
        CSLP_CLK_WAIT:
        begin
          if (cnt_done)
          begin
            state_q <= CSLP_RUN;
          end
        end
        default:
        begin
          state_q <= CSLP_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_stop_clock_request_n <= 1'b1;
      o_deep_sleep_n <= 1'b1;
      o_deeper_sleep_n <= 1'b1;
    end
    else
    begin
      // separate stop-clock output
      // Held through exit so release lands on an LPC edge
      o_stop_clock_request_n <= !(state_q == CSLP_STOP ||
        state_q == CSLP_DEEP || state_q == CSLP_DEEPER ||
        state_q == CSLP_DEEP_EXIT);
      o_deep_sleep_n <= !(state_q == CSLP_DEEP ||
        state_q == CSLP_DEEPER || state_q == CSLP_DEEP_EXIT ||
        state_q == CSLP_CLK_WAIT);
      o_deeper_sleep_n <= !(state_q == CSLP_DEEPER);
    end
  end

  // Power good held high during p-state activity so context survives
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      pwr_meta_q <= 1'b0;
      pwr_sync_q <= 1'b0;
      o_cpu_power_good <= 1'b0;
    end
    else
    begin
      pwr_meta_q <= i_power_ok;
      pwr_sync_q <= pwr_meta_q;
      o_cpu_power_good <= pwr_sync_q || (o_cpu_power_good &&
        sync_if.pstate_busy);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_deeper_in_deep;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    !o_deeper_sleep_n |-> !o_deep_sleep_n;
  endproperty
  a_deeper_in_deep: assert property (p_deeper_in_deep)
    else $error("deeper sleep outside deep sleep");

  property p_deep_exit_clock;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    $rose(o_deep_sleep_n) |-> o_stop_clock_request_n &&
      $past(o_stop_clock_request_n, 2);
  endproperty
  a_deep_exit_clock: assert property (p_deep_exit_clock)
    else $error("deep sleep released while clock stopped");

  property p_deep_entry;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    $fell(o_deep_sleep_n) |-> !o_stop_clock_request_n;
  endproperty
  a_deep_entry: assert property (p_deep_entry)
    else $error("deep sleep without stop clock");

  property p_deep_release;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (state_q == CSLP_RUN) |=> o_deep_sleep_n;
  endproperty
  a_deep_release: assert property (p_deep_release)
    else $error("deep sleep low while running");

  property p_deeper_release;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (state_q == CSLP_DEEPER && !sync_if.deeper_req) |=> ##1
      o_deeper_sleep_n;
  endproperty
  a_deeper_release: assert property (p_deeper_release)
    else $error("deeper sleep not released");

  property p_deeper_entry;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (state_q == CSLP_DEEP && sync_if.sleep_req && sync_if.deeper_req)
      |=> ##1 !o_deeper_sleep_n;
  endproperty
  a_deeper_entry: assert property (p_deeper_entry)
    else $error("deeper sleep not asserted");

  property p_pgood_hold;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (o_cpu_power_good && sync_if.pstate_busy) |=> o_cpu_power_good;
  endproperty
  a_pgood_hold: assert property (p_pgood_hold)
    else $error("power good dropped during p-state change");

  property p_stop_on_lpc;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    $changed(o_stop_clock_request_n) |-> $past(sync_if.lpc_clk_rise, 2);
  endproperty
  a_stop_on_lpc: assert property (p_stop_on_lpc)
    else $error("stop clock changed off an LPC edge");

  property p_stop_sync;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (state_q == CSLP_STOP && $past(state_q) == CSLP_RUN) |->
      $past(sync_if.lpc_clk_rise);
  endproperty
  a_stop_sync: assert property (p_stop_sync)
    else $error("stop clock not aligned to LPC clock");

  property p_separate;
    @(posedge i_clk_sys) disable iff (!i_rst_b)
    (state_q == CSLP_CLK_WAIT) |=> o_stop_clock_request_n;
  endproperty
  a_separate: assert property (p_separate)
    else $error("stop clock held during clock restart");
endmodule

//--- rtl/cslp_sync_if.sv
`timescale 1ns/10ps
interface cslp_sync_if;
  logic lpc_clk_rise;
  logic sleep_req;
  logic deeper_req;
  logic pstate_busy;
  modport src (output lpc_clk_rise, output sleep_req, output deeper_req,
    output pstate_busy);
  modport dst (input lpc_clk_rise, input sleep_req, input deeper_req,
    input pstate_busy);
endinterface

//--- tb/cslp_cpu_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Processor side of the sleep sideband
// ----------------------------------------------------------------
module cslp_cpu_model
(
  input wire logic i_clk_sys,  // Host clock
  input wire logic i_stop_n,   // Stop-clock request, active low
  input wire logic i_deep_n,   // Deep sleep, active low
  input wire logic i_deeper_n, // Deeper sleep, active low
  output logic o_core_run,     // Core clock running
  output logic o_deeper        // Deeper sleep entered
);
  always_ff @(posedge i_clk_sys)
  begin
    o_core_run <= i_stop_n & i_deep_n;
  end

  // Deeper only counts from deep sleep
  always_ff @(posedge i_clk_sys)
  begin
    o_deeper <= ~i_deeper_n & ~i_deep_n;
  end
endmodule

//--- tb/cslp_seq_test.sv
`timescale 1ns/10ps
module cslp_seq_test;
  import cslp_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic lpc = 1'b0;
  logic sleep = 1'b0;
  logic deeper = 1'b0;
  logic busy = 1'b0;
  logic pok = 1'b0;
  logic stop_n, deep_n, deeper_n, pg, core_run, in_deeper;
  int n_mismatch = 0;
  int samples_checked = 0;

  // Long setup so an early drop of sleep is seen in the stop phase
  cslp_seq #(.SETUP_CYC(8), .RUN_CYC(3)) DUT (.i_clk_sys(clk),
    .i_rst_b(rst_b), .i_lpc_clk(lpc), .i_sleep_req(sleep),
    .i_deeper_req(deeper), .i_pstate_busy(busy), .i_power_ok(pok),
    .o_stop_clock_request_n(stop_n), .o_deep_sleep_n(deep_n),
    .o_deeper_sleep_n(deeper_n), .o_cpu_power_good(pg));
  cslp_cpu_model u_cpu (.i_clk_sys(clk), .i_stop_n(stop_n),
    .i_deep_n(deep_n), .i_deeper_n(deeper_n), .o_core_run(core_run),
    .o_deeper(in_deeper));

  initial forever #2 clk = ~clk;
  initial forever
  begin
    repeat (4) @(posedge clk);
    #1 lpc = ~lpc;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return stop_n;
      1: return deep_n;
      2: return deeper_n;
      default: return pg;
    endcase
  endfunction

  // Bounded so a stuck output shows as a mismatch, not a hang
  task automatic wait_on(input int k, input logic v);
    for (int i = 0; i < 200 && pick(k) !== v; i++)
      step(1);
  endtask

  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time,
        seen, exp);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic t_reset();
    check({stop_n, deep_n}, 2'b11);
    check({deeper_n, pg}, 2'b10);
  endtask

  task automatic t_sleep();
    sleep = 1'b1;
    wait_on(0, 1'b0);
    check({stop_n, deep_n}, 2'b01);
    wait_on(1, 1'b0);
    step(2);
    check({deep_n, core_run}, 2'b00);
    deeper = 1'b1;
    wait_on(2, 1'b0);
    step(2);
    check({deep_n, in_deeper}, 2'b01);
    deeper = 1'b0;
    wait_on(2, 1'b1);
    check({deep_n, deeper_n}, 2'b01);
    sleep = 1'b0;
    wait_on(0, 1'b1);
    check({stop_n, deep_n}, 2'b10);
    wait_on(1, 1'b1);
    check({stop_n, deep_n}, 2'b11);
  endtask

  task automatic t_abort();
    logic held;
    held = 1'b1;
    sleep = 1'b1;
    wait_on(0, 1'b0);
    sleep = 1'b0;
    repeat (30)
    begin
      step(1);
      held = held & deep_n;
    end
    check({held, stop_n}, 2'b11);
  endtask

  task automatic t_deeper_first();
    deeper = 1'b1;
    step(20);
    check({deeper_n, stop_n}, 2'b11);
    sleep = 1'b1;
    wait_on(2, 1'b0);
    check({deep_n, deeper_n}, 2'b00);
    sleep = 1'b0;
    wait_on(2, 1'b1);
    check({deep_n, deeper_n}, 2'b01);
    deeper = 1'b0;
    wait_on(1, 1'b1);
    check({deep_n, stop_n}, 2'b11);
  endtask

  task automatic t_power();
    pok = 1'b1;
    wait_on(3, 1'b1);
    check({pg, stop_n}, 2'b11);
    busy = 1'b1;
    step(6);
    pok = 1'b0;
    step(12);
    check({pg, busy}, 2'b11);
    busy = 1'b0;
    wait_on(3, 1'b0);
    check({pg, busy}, 2'b00);
  endtask

  initial
  begin
    step(16);
    rst_b = 1'b1;
    t_reset();
    t_sleep();
    t_abort();
    t_deeper_first();
    t_power();
    close_out();
  end

  // Whole run needs well under 2000 cycles
  initial
  begin
    step(20000);
    n_mismatch++;
    close_out();
  end
endmodule
